// file: core/addr_map_pkg.sv
// constants for the emulation memory address mapper
package addr_map_pkg;
  localparam int          ADDR_W        = 32;
  localparam int          NIB_LSB       = 28;
  localparam int          NUM_CS        = 8;
  localparam int          CNT_W         = 32;
  localparam int          CS_SEVEN      = 7;
  localparam logic [3:0]  NIB_ZERO      = 4'h0;
  localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
  localparam logic [31:0] CNT_RST       = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE       = 32'h0000_0001;
  // counter wraps about every 22.9 minutes at the chosen count rate
  localparam real         WRAP_MINUTES  = 22.9;
  localparam logic [7:0]  WARN_UPPER    = 8'hAC; // warning number 172
  // halt status codes
  localparam logic [1:0]  HALT_NONE     = 2'h0;
  localparam logic [1:0]  HALT_DRAM     = 2'h1;
  localparam logic [1:0]  HALT_PARITY   = 2'h2;
endpackage

// file: core/nibble_rebuild.sv
// rebuilds the upper address nibble from chip-select programming
`timescale 1ns/10ps
module nibble_rebuild (
  // chip-select state
  input  wire logic [7:0]  cs_active,
  input  wire logic [31:0] cs_base [8],
  // rebuilt nibble
  output logic [3:0]       nibble,
  output logic             hit
);
  always_comb begin
    nibble = addr_map_pkg::NIB_ZERO;
    hit    = 1'b0;
    for (int i = addr_map_pkg::NUM_CS - 1; i >= 0; i--) begin
      if (cs_active[i]) begin
        nibble = cs_base[i][31:28];
        hit    = 1'b1;
      end
    end
  end
endmodule // nibble_rebuild

// file: core/emulation_memory_address_mapper.sv
// emulation memory address mapper and trace qualifier
// Operation
// - in write-strobe mode rebuild upper nibble from chip selects for analyzer
// - in write-strobe mode mapper sees zero upper nibble, lower 28 bits only
// - target-routed accesses carry original upper nibble unchanged
// - aliased emulation access raises no error, analyzer keeps rebuilt address
// - DRAM chip select reaching emulation memory halts to monitor with status
// - emulation access with parity enabled halts to monitor
// - in write-strobe mode warn number 172 per chip select decoding a nonzero unseen upper nibble
// - warn rebuilt nibble may be invalid when select seven is plain chip select
// - cycle is DMA only when function code bit three high
// - relative mode flags first stored state after each counter wrap
// - absolute mode flags every stored state after first wrap
// - relative mode elapsed count corrected for wrap, never negative
`timescale 1ns/10ps
module emulation_memory_address_mapper (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // processor bus (from pins)
  input  wire logic        cycle_strobe,
  input  wire logic [31:0] cpu_addr,
  input  wire logic        function_code_bit_three,
  input  wire logic [7:0]  cs_active,
  // configuration
  input  wire logic        upper_is_we,
  input  wire logic [31:0] cs_base [8],
  input  wire logic [31:0] cs_mask [8],
  input  wire logic [7:0]  cs_is_dram,
  input  wire logic [7:0]  cs_parity_en,
  input  wire logic [7:0]  cs_valid,
  input  wire logic        shared_select_pin_seven_is_cs,
  input  wire logic        absolute_mode,
  // mapper decision from the memory map
  input  wire logic        map_is_emul,
  // outputs
  output logic [31:0]      mapper_addr,
  output logic [31:0]      target_addr,
  output logic [31:0]      trace_addr,
  output logic             trace_valid,
  output logic             trace_dma,
  output logic [31:0]      trace_count,
  output logic             trace_overflow,
  output logic             halt_req,
  output logic [1:0]       halt_status,
  output logic [7:0]       warn_upper_cs,
  output logic [7:0]       warn_number,
  output logic             warn_nibble_invalid
);
  // reset release
  logic rst_s1_q, rstn_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rstn_q   <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rstn_q   <= rst_s1_q;
    end
  end

  // pin synchronisers
  logic [31:0] addr_s1_q, addr_s2_q;
  logic        stb_s1_q, stb_s2_q, fc_s1_q, fc_s2_q;
  logic [7:0]  cs_s1_q, cs_s2_q;
  always_ff @(posedge clk_sys or negedge rstn_q) begin
    if (!rstn_q) begin
      addr_s1_q <= addr_map_pkg::ADDR_RST;
      addr_s2_q <= addr_map_pkg::ADDR_RST;
      stb_s1_q  <= 1'b0;
      stb_s2_q  <= 1'b0;
      fc_s1_q   <= 1'b0;
      fc_s2_q   <= 1'b0;
      cs_s1_q   <= 8'h00;
      cs_s2_q   <= 8'h00;
    end else begin
      addr_s1_q <= cpu_addr;
      addr_s2_q <= addr_s1_q;
      stb_s1_q  <= cycle_strobe;
      stb_s2_q  <= stb_s1_q;
      fc_s1_q   <= function_code_bit_three;
      fc_s2_q   <= fc_s1_q;
      cs_s1_q   <= cs_active;
      cs_s2_q   <= cs_s1_q;
    end
  end

  // upper nibble of a bus word
  function automatic logic [3:0] upper_nib(input logic [31:0] word);
    return word[addr_map_pkg::ADDR_W-1:addr_map_pkg::NIB_LSB];
  endfunction

  // same word with its upper nibble replaced
  function automatic logic [31:0] with_nib(input logic [31:0] word, input logic [3:0] nib);
    logic [31:0] res;
    res = word;
    res[addr_map_pkg::ADDR_W-1:addr_map_pkg::NIB_LSB] = nib;
    return res;
  endfunction

  logic [3:0] rebuilt_nib;
  logic       rebuilt_hit;
  nibble_rebuild u_rebuild (
    .cs_active (cs_s2_q),
    .cs_base   (cs_base),
    .nibble    (rebuilt_nib),
    .hit       (rebuilt_hit)
  );

  // next values of the per-cycle outputs
  logic [31:0] mapper_addr_d, target_addr_d, trace_addr_d;
  logic        trace_valid_d, trace_dma_d, halt_req_d, emul_hit;
  logic [1:0]  halt_status_d;
  logic [7:0]  warn_upper_cs_d, warn_number_d;
  logic        warn_nibble_invalid_d;

  always_comb begin
    mapper_addr_d = addr_s2_q;
    if (upper_is_we) begin
      mapper_addr_d = with_nib(addr_s2_q, addr_map_pkg::NIB_ZERO);
    end
    target_addr_d = addr_s2_q;
    trace_addr_d  = addr_s2_q;
    if (upper_is_we && rebuilt_hit) begin
      trace_addr_d = with_nib(addr_s2_q, rebuilt_nib);
    end
    emul_hit      = stb_s2_q && map_is_emul;
    halt_req_d    = 1'b0;
    halt_status_d = addr_map_pkg::HALT_NONE;
    // dram reported first when both faults apply
    if (emul_hit && |(cs_s2_q & cs_is_dram)) begin
      halt_req_d    = 1'b1;
      halt_status_d = addr_map_pkg::HALT_DRAM;
    end else if (emul_hit && |(cs_s2_q & cs_parity_en)) begin
      halt_req_d    = 1'b1;
      halt_status_d = addr_map_pkg::HALT_PARITY;
    end
    // zero-nibble aliasing itself never raises a halt
    trace_valid_d = stb_s2_q;
    trace_dma_d   = stb_s2_q && fc_s2_q;
    // diagnostics
    warn_upper_cs_d = 8'h00;
    for (int i = 0; i < addr_map_pkg::NUM_CS; i++) begin
      if (upper_is_we && cs_valid[i] && (upper_nib(cs_mask[i]) != addr_map_pkg::NIB_ZERO)
          && (upper_nib(cs_base[i]) != addr_map_pkg::NIB_ZERO)) begin
        warn_upper_cs_d[i] = 1'b1;
      end
    end
    warn_number_d = (|warn_upper_cs_d) ? addr_map_pkg::WARN_UPPER : 8'h00;
    // rebuilt nibble is only as good as the chip-select decode
    warn_nibble_invalid_d = shared_select_pin_seven_is_cs;
  end

  always_ff @(posedge clk_sys or negedge rstn_q) begin
    if (!rstn_q) begin
      mapper_addr         <= addr_map_pkg::ADDR_RST;
      target_addr         <= addr_map_pkg::ADDR_RST;
      trace_addr          <= addr_map_pkg::ADDR_RST;
      trace_valid         <= 1'b0;
      trace_dma           <= 1'b0;
      halt_req            <= 1'b0;
      halt_status         <= addr_map_pkg::HALT_NONE;
      warn_upper_cs       <= 8'h00;
      warn_number         <= 8'h00;
      warn_nibble_invalid <= 1'b0;
    end else begin
      mapper_addr         <= mapper_addr_d;
      target_addr         <= target_addr_d;
      trace_addr          <= trace_addr_d;
      trace_valid         <= trace_valid_d;
      trace_dma           <= trace_dma_d;
      halt_req            <= halt_req_d;
      halt_status         <= halt_status_d;
      warn_upper_cs       <= warn_upper_cs_d;
      warn_number         <= warn_number_d;
      warn_nibble_invalid <= warn_nibble_invalid_d;
    end
  end

  // free running time counter and per-state count
  logic [31:0] cnt_q, cnt_d, last_cnt_q, last_cnt_d, trace_count_d;
  logic        wrap_pend_q, wrap_pend_d, wrapped_q, wrapped_d, trace_overflow_d;

  always_comb begin
    cnt_d       = cnt_q + addr_map_pkg::CNT_ONE;
    wrap_pend_d = wrap_pend_q;
    wrapped_d   = wrapped_q;
    if (cnt_d == addr_map_pkg::CNT_RST) begin
      wrap_pend_d = 1'b1;
      wrapped_d   = 1'b1;
    end
    last_cnt_d       = last_cnt_q;
    trace_count_d    = trace_count;
    trace_overflow_d = trace_overflow;
    if (stb_s2_q) begin
      last_cnt_d = cnt_q;
      if (absolute_mode) begin
        trace_count_d    = cnt_q;
        trace_overflow_d = wrapped_q;
      end else begin
        // modulo subtraction never goes negative
        trace_count_d    = cnt_q - last_cnt_q;
        trace_overflow_d = wrap_pend_q;
        // a wrap in the cycle of the store stays pending for the next one
        wrap_pend_d      = (cnt_d == addr_map_pkg::CNT_RST);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn_q) begin
    if (!rstn_q) begin
      trace_count    <= addr_map_pkg::CNT_RST;
      trace_overflow <= 1'b0;
      cnt_q          <= addr_map_pkg::CNT_RST;
      last_cnt_q     <= addr_map_pkg::CNT_RST;
      wrap_pend_q    <= 1'b0;
      wrapped_q      <= 1'b0;
    end else begin
      trace_count    <= trace_count_d;
      trace_overflow <= trace_overflow_d;
      cnt_q          <= cnt_d;
      last_cnt_q     <= last_cnt_d;
      wrap_pend_q    <= wrap_pend_d;
      wrapped_q      <= wrapped_d;
    end
  end
endmodule // emulation_memory_address_mapper

// file: dv/target_cs_model.sv
// chip-select decoder standing on the target bus
`timescale 1ns/10ps
module target_cs_model (
  // address and chip-select programming
  input  wire logic [31:0] addr,
  input  wire logic [31:0] base [8],
  input  wire logic [31:0] mask [8],
  input  wire logic [7:0]  valid,
  // decoded selects
  output logic [7:0]       active
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      active[i] = valid[i] && ((addr ^ base[i]) & mask[i]) == 32'h0000_0000;
    end
  end
endmodule // target_cs_model

// file: dv/addr_mapper_sva.sv
// assertion checker for the address mapper
`timescale 1ns/10ps
module addr_mapper_sva (
  // clock, reset and inputs
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        cycle_strobe,
  input wire logic [31:0] cpu_addr,
  input wire logic        function_code_bit_three,
  input wire logic [7:0]  cs_active,
  input wire logic [7:0]  cs_is_dram,
  input wire logic [7:0]  cs_parity_en,
  input wire logic        upper_is_we,
  input wire logic        shared_select_pin_seven_is_cs,
  input wire logic        map_is_emul,
  // outputs
  input wire logic [31:0] mapper_addr,
  input wire logic [31:0] target_addr,
  input wire logic        trace_valid,
  input wire logic        trace_dma,
  input wire logic        halt_req,
  input wire logic [1:0]  halt_status,
  input wire logic [7:0]  warn_upper_cs,
  input wire logic [7:0]  warn_number,
  input wire logic        warn_nibble_invalid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_strobe_to_trace: assert property (cycle_strobe |-> ##3 trace_valid)
    else $error("strobe not traced");
  a_target_nibble_kept: assert property (trace_valid |-> target_addr == $past(cpu_addr, 3))
    else $error("target address altered");
  a_mapper_low_bits: assert property (trace_valid |->
    mapper_addr[27:0] == $past(cpu_addr[27:0], 3))
    else $error("mapper low bits wrong");
  a_mapper_upper_zero: assert property (trace_valid && $past(upper_is_we) |->
    mapper_addr[31:28] == 4'h0)
    else $error("mapper upper nibble not zero");
  a_parity_halt: assert property (trace_valid && $past(map_is_emul) &&
    !(|($past(cs_active, 3) & cs_is_dram)) && |($past(cs_active, 3) & cs_parity_en)
    |-> halt_req && halt_status == 2'h2)
    else $error("parity access not halted");
  a_dma_from_fc: assert property (trace_valid |-> trace_dma == $past(function_code_bit_three, 3))
    else $error("dma tag wrong");
  a_dram_halt: assert property (trace_valid && $past(map_is_emul) &&
    |($past(cs_active, 3) & cs_is_dram) |-> halt_req && halt_status == 2'h1)
    else $error("dram access not halted");
  a_halt_needs_cycle: assert property (halt_req |-> trace_valid && $past(map_is_emul))
    else $error("halt without emulation cycle");
  a_warn_number: assert property (|warn_upper_cs |-> warn_number == 8'hAC)
    else $error("warning number wrong");
  a_nibble_warn: assert property (shared_select_pin_seven_is_cs |=> warn_nibble_invalid)
    else $error("select seven warning missing");
endmodule // addr_mapper_sva
bind emulation_memory_address_mapper addr_mapper_sva chk_u (.clk_sys, .resetn, .cycle_strobe,
  .cpu_addr, .function_code_bit_three, .cs_active, .cs_is_dram, .cs_parity_en, .upper_is_we,
  .shared_select_pin_seven_is_cs, .map_is_emul, .mapper_addr, .target_addr, .trace_valid,
  .trace_dma, .halt_req, .halt_status, .warn_upper_cs, .warn_number, .warn_nibble_invalid);

// file: dv/test_emulation_memory_address_mapper.sv
// self-checking bench for the address mapper
`timescale 1ns/10ps
module test_emulation_memory_address_mapper;
  logic        clk_sys = 0, resetn = 0, stb = 0, fc = 0, we = 1, pin7 = 0, abs_m = 0;
  logic [31:0] a = 0, p1 = 0, p2 = 0, c, m_a, t_a, tr_a, cnt, base [8], mask [8];
  logic [7:0]  act, warn, wnum;
  logic [1:0]  hs;
  logic        tv, td, ovf, hr, wni;
  int          bad_count = 0, tests_run = 0;
  typedef struct packed { logic [31:0] a, m; logic [1:0] h; logic f; } row_t;
  row_t rows [4] = '{'{32'h2000_0010, 32'h0000_0010, 2'h0, 1'b0},
    '{32'h1040_0000, 32'h0040_0000, 2'h0, 1'b1},
    '{32'h1000_0000, 32'h0000_0000, 2'h1, 1'b0}, '{32'h0004_0004, 32'h0004_0004, 2'h2, 1'b0}};
  initial forever #12.5 clk_sys = ~clk_sys;
  // memory map: emulation below 80000h, aligned two cycles after the pins
  always @(posedge clk_sys) begin
    p1 <= #1 a;
    p2 <= #1 p1;
  end
  target_cs_model cs_u (.addr(a), .base, .mask, .valid(8'h4F), .active(act));
  emulation_memory_address_mapper dut_u (.clk_sys, .resetn, .cycle_strobe(stb), .cpu_addr(a),
    .function_code_bit_three(fc), .cs_active(act), .upper_is_we(we), .cs_base(base),
    .cs_mask(mask), .cs_is_dram(8'h02), .cs_parity_en(8'h08), .cs_valid(8'h4F),
    .shared_select_pin_seven_is_cs(pin7), .absolute_mode(abs_m),
    .map_is_emul({we ? 4'h0 : p2[31:28], p2[27:0]} < 32'h0008_0000), .mapper_addr(m_a),
    .target_addr(t_a), .trace_addr(tr_a), .trace_valid(tv), .trace_dma(td), .trace_count(cnt),
    .trace_overflow(ovf), .halt_req(hr), .halt_status(hs), .warn_upper_cs(warn),
    .warn_number(wnum), .warn_nibble_invalid(wni));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic strobe(input logic [31:0] ad, input logic f);
    a <= ad;
    fc <= f;
    stb <= 1;
    @(posedge clk_sys) #1;
  endtask
  task automatic await;
    int n;
    n = 0;
    stb <= 0;
    while (tv !== 1'b1 && n < 8) begin
      @(posedge clk_sys) #1;
      n++;
    end
    if (tv !== 1'b1) begin
      bad_count++;
      conclude();
    end
  endtask
  initial begin
    for (int i = 0; i < 8; i++) begin
      base[i] = 0;
      mask[i] = 0;
    end
    base[1] = 32'h1000_0000;
    base[2] = 32'h1040_0000;
    base[3] = 32'h0004_0000;
    base[6] = 32'h2000_0000;
    mask[0] = 32'hFFC0_0000;
    mask[1] = 32'hFFC0_0000;
    mask[2] = 32'hFFC0_0000;
    mask[3] = 32'hFFFC_0000;
    mask[6] = 32'hE000_0000;
    repeat (20) @(posedge clk_sys);
    #1;
    check(warn, 8'h00);
    resetn = 1;
    repeat (4) @(posedge clk_sys) #1;
    check(warn, 8'h46);
    check(wnum, 8'hAC);
    check(wni, 0);
    foreach (rows[i]) begin
      strobe(rows[i].a, rows[i].f);
      await();
      check(m_a, rows[i].m);
      check(t_a, rows[i].a);
      check(tr_a, rows[i].a);
      check(td, rows[i].f);
      check({hr, hs}, {rows[i].h != 0, rows[i].h});
    end
    for (int k = 0; k < 2; k++) begin
      abs_m <= k[0];
      strobe(32'h0000_0100, 0);
      strobe(32'h0000_0104, 0);
      await();
      c = cnt;
      @(posedge clk_sys) #1;
      check(tv, 1);
      check(cnt, k ? c + 1 : 32'h1);
      check(ovf, 0);
    end
    pin7 <= 1;
    we <= 0;
    repeat (2) @(posedge clk_sys) #1;
    check(wni, 1);
    check(warn, 8'h00);
    strobe(32'h2000_0010, 0);
    await();
    check(m_a, 32'h2000_0010);
    check(t_a, 32'h2000_0010);
    check(tr_a, 32'h2000_0010);
    check({hr, hs}, 3'h0);
    conclude();
  end
endmodule // test_emulation_memory_address_mapper
